// ===== common/lane_tx_flag_consts.svh
// Offsets, field positions, reset values and sizes of the lane Tx latched flag bank
//
// Summary of operation
// - Tx failure per media lane latched, byte 135
// - Tx input loss per host lane, byte 136
// - Tx clock recovery unlock latched, byte 137
// - Tx equaliser failure latched, byte 138
// - Tx power high alarm latched, byte 139
// - Tx power low alarm latched, byte 140
// - Tx power high warning latched, byte 141
// - Tx power low warning latched, byte 142
// - Laser bias high alarm latched, byte 143
// - Laser bias low alarm latched, byte 144
// - Laser bias high warning latched, byte 145
// - Laser bias low warning latched, byte 146
// - Each flag bit masked from interrupt indication
`ifndef LANE_TX_FLAG_CONSTS_SVH
`define LANE_TX_FLAG_CONSTS_SVH

// ********************************************************************
// Register offsets within the page
// ********************************************************************
`define OFF_TX_FAILURE 8'h87
`define OFF_TX_INPUT_LOSS 8'h88
`define OFF_TX_CDR_UNLOCK 8'h89
`define OFF_TX_EQ_FAIL 8'h8a
`define OFF_TX_PWR_HI_ALARM 8'h8b
`define OFF_TX_PWR_LO_ALARM 8'h8c
`define OFF_TX_PWR_HI_WARN 8'h8d
`define OFF_TX_PWR_LO_WARN 8'h8e
`define OFF_BIAS_HI_ALARM 8'h8f
`define OFF_BIAS_LO_ALARM 8'h90
`define OFF_BIAS_HI_WARN 8'h91
`define OFF_BIAS_LO_WARN 8'h92

// ********************************************************************
// Sizes, groups and reset values
// ********************************************************************
`define NUM_FLAG_REGS 8'h0c
`define GRP_POWER_FIRST 4
`define GRP_BIAS_FIRST 8
`define FLAG_RESET 8'h00
`define RD_DATA_RESET 8'h00
`define UNMAPPED_DATA 8'h00

`endif

// ===== common/lane_tx_flag_pkg.sv
// Types shared by the lane Tx latched flag bank
package lane_tx_flag_pkg;

    // One byte per flag type, bit n covers lane n+1
    typedef logic [7:0] flag_byte_t;

    // Whole bank as an indexable array, index 0 is the Tx failure byte
    typedef logic [11:0][7:0] flag_bank_t;

    // Causes or masks for every flag byte, last field sits at index 0
    typedef struct packed {
        flag_byte_t bias_low_warn_latched;
        flag_byte_t bias_high_warn_latched;
        flag_byte_t bias_low_alarm_latched;
        flag_byte_t bias_high_alarm_latched;
        flag_byte_t tx_power_low_warn_latched;
        flag_byte_t tx_power_high_warn_latched;
        flag_byte_t tx_power_low_alarm_latched;
        flag_byte_t tx_power_high_alarm_latched;
        flag_byte_t tx_equaliser_fail_latched;
        flag_byte_t tx_clock_recovery_unlock_latched;
        flag_byte_t tx_input_loss_latched;
        flag_byte_t tx_failure_latched;
    } flag_bank_s;

    // State of one latched flag byte
    typedef struct packed {
        flag_byte_t flags;
    } flag_reg_state_s;

    // State of the read port and interrupt indication
    typedef struct packed {
        flag_byte_t rd_data;
        logic rd_valid;
        logic flag_int;
    } bank_state_s;

endpackage

// ===== rtl/lane_flag_reg.sv
// One 8-lane latched flag byte that clears when read
`timescale 1ns/1ps
`include "lane_tx_flag_consts.svh"

module lane_flag_reg (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [7:0] cause,
    input wire logic clear,
    output logic [7:0] flags
);

    lane_tx_flag_pkg::flag_reg_state_s state_q;
    lane_tx_flag_pkg::flag_reg_state_s state_d;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Set wins over clear so an event during the read is kept
    always_comb begin
        state_d = state_q;
        if (!enable) begin
            state_d.flags = `FLAG_RESET;
        end else begin
            state_d.flags = (state_q.flags & ~{8{clear}}) | cause;
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q.flags <= `FLAG_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign flags = state_q.flags;

endmodule

// ===== rtl/lane_tx_latched_flag_bank.sv
// Twelve latched per-lane Tx flag bytes with clear-when-read access
`timescale 1ns/1ps
`include "lane_tx_flag_consts.svh"

module lane_tx_latched_flag_bank (
    input wire logic clk,
    input wire logic rst,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    input wire lane_tx_flag_pkg::flag_bank_s flag_causes,
    input wire lane_tx_flag_pkg::flag_bank_s flag_masks,
    input wire logic [3:0] adv_tx_flags,
    input wire logic adv_power_mon,
    input wire logic adv_bias_mon,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic flag_int
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    lane_tx_flag_pkg::flag_bank_t cause_arr;
    lane_tx_flag_pkg::flag_bank_t mask_arr;
    lane_tx_flag_pkg::flag_bank_t flag_arr;
    logic [11:0] supported;
    logic [11:0] hit;
    logic [7:0] rel_addr;
    logic mapped;
    logic pending;
    lane_tx_flag_pkg::bank_state_s state_q;
    lane_tx_flag_pkg::bank_state_s state_d;

    // Struct view to indexable view, same bit layout
    assign cause_arr = lane_tx_flag_pkg::flag_bank_t'(flag_causes);
    assign mask_arr = lane_tx_flag_pkg::flag_bank_t'(flag_masks);

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Bank is contiguous, so one subtract replaces twelve compares
    assign rel_addr = rd_addr - `OFF_TX_FAILURE;
    assign mapped = rel_addr < `NUM_FLAG_REGS;

    // ****************************************************************
    // Flag bytes
    // ****************************************************************
    // Each Tx byte gated by its own advertisement bit, power and bias bytes by the one bit of their group
    generate
        for (genvar k = 0; k < 12; k++) begin : g_flag
            if (k < `GRP_POWER_FIRST) begin : g_tx
                assign supported[k] = adv_tx_flags[k];
            end else if (k < `GRP_BIAS_FIRST) begin : g_pwr
                assign supported[k] = adv_power_mon;
            end else begin : g_bias
                assign supported[k] = adv_bias_mon;
            end

            // A read of this byte clears it at the same edge it is captured
            assign hit[k] = rd_en && (rel_addr == 8'(k));

            // Bytes 135 to 146, bit 7 lane 8 down to bit 0 lane 1
            lane_flag_reg u_flag_reg (
                .clk(clk),
                .rst(rst),
                .enable(supported[k]),
                .cause(cause_arr[k]),
                .clear(hit[k]),
                .flags(flag_arr[k])
            );
        end
    endgenerate

    // ****************************************************************
    // Interrupt indication
    // ****************************************************************
    // Any unmasked latched bit raises the indication
    assign pending = |(flag_arr & ~mask_arr);

    // ****************************************************************
    // Read port and state update
    // ****************************************************************
    // Read data holds until the next read; unmapped bytes read zero
    always_comb begin
        state_d = state_q;
        state_d.rd_valid = rd_en;
        state_d.flag_int = pending;
        if (rd_en) begin
            if (mapped) begin
                state_d.rd_data = flag_arr[rel_addr[3:0]];
            end else begin
                state_d.rd_data = `UNMAPPED_DATA;
            end
        end
    end

    // Register the whole state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q.rd_data <= `RD_DATA_RESET;
            state_q.rd_valid <= 1'b0;
            state_q.flag_int <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rd_data = state_q.rd_data;
    assign rd_valid = state_q.rd_valid;
    assign flag_int = state_q.flag_int;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // A read returns the byte as it stood just before the read edge
    property p_read_data(int k, logic [7:0] off);
        !rst && rd_en && rd_addr == off |=> rd_valid && rd_data == $past(flag_arr[k]);
    endproperty

    // A read with no live cause leaves the byte empty
    property p_read_clear(int k, logic [7:0] off);
        rd_en && rd_addr == off && cause_arr[k] == 8'h00 |=> flag_arr[k] == 8'h00;
    endproperty

    a_tx_fail_read: assert property (p_read_data(0, `OFF_TX_FAILURE))
        else $error("Tx failure byte read data wrong");
    a_tx_fail_clear: assert property (p_read_clear(0, `OFF_TX_FAILURE))
        else $error("Tx failure byte not cleared by read");

    a_in_loss_read: assert property (p_read_data(1, `OFF_TX_INPUT_LOSS))
        else $error("Input loss byte read data wrong");
    a_in_loss_clear: assert property (p_read_clear(1, `OFF_TX_INPUT_LOSS))
        else $error("Input loss byte not cleared by read");

    a_cdr_read: assert property (p_read_data(2, `OFF_TX_CDR_UNLOCK))
        else $error("Clock recovery byte read data wrong");
    a_cdr_clear: assert property (p_read_clear(2, `OFF_TX_CDR_UNLOCK))
        else $error("Clock recovery byte not cleared by read");

    a_eq_read: assert property (p_read_data(3, `OFF_TX_EQ_FAIL))
        else $error("Equaliser byte read data wrong");
    a_eq_clear: assert property (p_read_clear(3, `OFF_TX_EQ_FAIL))
        else $error("Equaliser byte not cleared by read");

    a_pwr_ha_read: assert property (p_read_data(4, `OFF_TX_PWR_HI_ALARM))
        else $error("Power high alarm read data wrong");
    a_pwr_ha_clear: assert property (p_read_clear(4, `OFF_TX_PWR_HI_ALARM))
        else $error("Power high alarm not cleared by read");

    a_pwr_la_read: assert property (p_read_data(5, `OFF_TX_PWR_LO_ALARM))
        else $error("Power low alarm read data wrong");
    a_pwr_la_clear: assert property (p_read_clear(5, `OFF_TX_PWR_LO_ALARM))
        else $error("Power low alarm not cleared by read");

    a_pwr_hw_read: assert property (p_read_data(6, `OFF_TX_PWR_HI_WARN))
        else $error("Power high warning read data wrong");
    a_pwr_hw_clear: assert property (p_read_clear(6, `OFF_TX_PWR_HI_WARN))
        else $error("Power high warning not cleared by read");

    a_pwr_lw_read: assert property (p_read_data(7, `OFF_TX_PWR_LO_WARN))
        else $error("Power low warning read data wrong");
    a_pwr_lw_clear: assert property (p_read_clear(7, `OFF_TX_PWR_LO_WARN))
        else $error("Power low warning not cleared by read");

    a_bias_ha_read: assert property (p_read_data(8, `OFF_BIAS_HI_ALARM))
        else $error("Bias high alarm read data wrong");
    a_bias_ha_clear: assert property (p_read_clear(8, `OFF_BIAS_HI_ALARM))
        else $error("Bias high alarm not cleared by read");

    a_bias_la_read: assert property (p_read_data(9, `OFF_BIAS_LO_ALARM))
        else $error("Bias low alarm read data wrong");
    a_bias_la_clear: assert property (p_read_clear(9, `OFF_BIAS_LO_ALARM))
        else $error("Bias low alarm not cleared by read");

    a_bias_hw_read: assert property (p_read_data(10, `OFF_BIAS_HI_WARN))
        else $error("Bias high warning read data wrong");
    a_bias_hw_clear: assert property (p_read_clear(10, `OFF_BIAS_HI_WARN))
        else $error("Bias high warning not cleared by read");

    a_bias_lw_read: assert property (p_read_data(11, `OFF_BIAS_LO_WARN))
        else $error("Bias low warning read data wrong");
    a_bias_lw_clear: assert property (p_read_clear(11, `OFF_BIAS_LO_WARN))
        else $error("Bias low warning not cleared by read");

    // Interrupt follows unmasked flags one cycle later
    a_mask_gates_int: assert property (
        !rst |=> flag_int == $past(|(flag_arr & ~mask_arr)))
        else $error("Interrupt does not follow unmasked flags");

    // Fully masked bank never raises the interrupt
    a_all_masked: assert property (
        mask_arr == '1 ##1 mask_arr == '1 |-> !flag_int)
        else $error("Interrupt raised with every flag masked");

    // Per byte: stickiness, set over clear, and unsupported zero
    generate
        for (genvar k = 0; k < 12; k++) begin : g_chk
            a_sticky_hold: assert property (
                !rst && supported[k] && !hit[k] |=>
                    (flag_arr[k] & $past(flag_arr[k])) == $past(flag_arr[k]))
                else $error("Latched flag lost without a read");

            a_set_wins: assert property (
                !rst && supported[k] && cause_arr[k] != 8'h00 |=>
                    (flag_arr[k] & $past(cause_arr[k])) == $past(cause_arr[k]))
                else $error("Live cause not latched");

            a_unsup_zero: assert property (
                !supported[k] |=> flag_arr[k] == 8'h00)
                else $error("Unsupported flag byte not zero");
        end
    endgenerate

    // Unmapped offsets answer with zero
    a_unmapped_zero: assert property (
        !rst && rd_en && !mapped |=> rd_valid && rd_data == 8'h00)
        else $error("Unmapped read returned nonzero data");

    // Read valid is a single-cycle answer to each request
    a_valid_pulse: assert property (
        !rd_en |=> !rd_valid)
        else $error("Read valid without a request");

    // ****************************************************************
    // Per-byte interrupt, support and read checks
    // ****************************************************************
    // Any unmasked latched bit of this byte raises the indication next cycle
    property p_int_raise(int k);
        !rst && (flag_arr[k] & ~mask_arr[k]) != 8'h00 |=> flag_int;
    endproperty

    // A byte whose group was unsupported at the previous edge reads zero
    property p_unsup_read(int k, logic [7:0] off);
        rd_en && rd_addr == off && $past(!supported[k]) |=> rd_data == 8'h00;
    endproperty

    // A cause live at the read edge survives the clear of that read
    property p_read_keep(int k, logic [7:0] off);
        !rst && rd_en && rd_addr == off && supported[k] |=>
            (flag_arr[k] & $past(cause_arr[k])) == $past(cause_arr[k]);
    endproperty

    a_tx_fail_int: assert property (p_int_raise(0))
        else $error("Tx failure byte did not raise interrupt");
    a_tx_fail_unsup: assert property (p_unsup_read(0, `OFF_TX_FAILURE))
        else $error("Unsupported Tx failure byte read nonzero");
    a_tx_fail_keep: assert property (p_read_keep(0, `OFF_TX_FAILURE))
        else $error("Tx failure cause lost by read");

    a_in_loss_int: assert property (p_int_raise(1))
        else $error("Input loss byte did not raise interrupt");
    a_in_loss_unsup: assert property (p_unsup_read(1, `OFF_TX_INPUT_LOSS))
        else $error("Unsupported input loss byte read nonzero");
    a_in_loss_keep: assert property (p_read_keep(1, `OFF_TX_INPUT_LOSS))
        else $error("Input loss cause lost by read");

    a_cdr_int: assert property (p_int_raise(2))
        else $error("Clock recovery byte did not raise interrupt");
    a_cdr_unsup: assert property (p_unsup_read(2, `OFF_TX_CDR_UNLOCK))
        else $error("Unsupported clock recovery byte read nonzero");
    a_cdr_keep: assert property (p_read_keep(2, `OFF_TX_CDR_UNLOCK))
        else $error("Clock recovery cause lost by read");

    a_eq_int: assert property (p_int_raise(3))
        else $error("Equaliser byte did not raise interrupt");
    a_eq_unsup: assert property (p_unsup_read(3, `OFF_TX_EQ_FAIL))
        else $error("Unsupported equaliser byte read nonzero");
    a_eq_keep: assert property (p_read_keep(3, `OFF_TX_EQ_FAIL))
        else $error("Equaliser cause lost by read");

    a_pwr_ha_int: assert property (p_int_raise(4))
        else $error("Power high alarm did not raise interrupt");
    a_pwr_ha_unsup: assert property (p_unsup_read(4, `OFF_TX_PWR_HI_ALARM))
        else $error("Unsupported power high alarm read nonzero");
    a_pwr_ha_keep: assert property (p_read_keep(4, `OFF_TX_PWR_HI_ALARM))
        else $error("Power high alarm cause lost by read");

    a_pwr_la_int: assert property (p_int_raise(5))
        else $error("Power low alarm did not raise interrupt");
    a_pwr_la_unsup: assert property (p_unsup_read(5, `OFF_TX_PWR_LO_ALARM))
        else $error("Unsupported power low alarm read nonzero");
    a_pwr_la_keep: assert property (p_read_keep(5, `OFF_TX_PWR_LO_ALARM))
        else $error("Power low alarm cause lost by read");

    a_pwr_hw_int: assert property (p_int_raise(6))
        else $error("Power high warning did not raise interrupt");
    a_pwr_hw_unsup: assert property (p_unsup_read(6, `OFF_TX_PWR_HI_WARN))
        else $error("Unsupported power high warning read nonzero");
    a_pwr_hw_keep: assert property (p_read_keep(6, `OFF_TX_PWR_HI_WARN))
        else $error("Power high warning cause lost by read");

    a_pwr_lw_int: assert property (p_int_raise(7))
        else $error("Power low warning did not raise interrupt");
    a_pwr_lw_unsup: assert property (p_unsup_read(7, `OFF_TX_PWR_LO_WARN))
        else $error("Unsupported power low warning read nonzero");
    a_pwr_lw_keep: assert property (p_read_keep(7, `OFF_TX_PWR_LO_WARN))
        else $error("Power low warning cause lost by read");

    a_bias_ha_int: assert property (p_int_raise(8))
        else $error("Bias high alarm did not raise interrupt");
    a_bias_ha_unsup: assert property (p_unsup_read(8, `OFF_BIAS_HI_ALARM))
        else $error("Unsupported bias high alarm read nonzero");
    a_bias_ha_keep: assert property (p_read_keep(8, `OFF_BIAS_HI_ALARM))
        else $error("Bias high alarm cause lost by read");

    a_bias_la_int: assert property (p_int_raise(9))
        else $error("Bias low alarm did not raise interrupt");
    a_bias_la_unsup: assert property (p_unsup_read(9, `OFF_BIAS_LO_ALARM))
        else $error("Unsupported bias low alarm read nonzero");
    a_bias_la_keep: assert property (p_read_keep(9, `OFF_BIAS_LO_ALARM))
        else $error("Bias low alarm cause lost by read");

    a_bias_hw_int: assert property (p_int_raise(10))
        else $error("Bias high warning did not raise interrupt");
    a_bias_hw_unsup: assert property (p_unsup_read(10, `OFF_BIAS_HI_WARN))
        else $error("Unsupported bias high warning read nonzero");
    a_bias_hw_keep: assert property (p_read_keep(10, `OFF_BIAS_HI_WARN))
        else $error("Bias high warning cause lost by read");

    a_bias_lw_int: assert property (p_int_raise(11))
        else $error("Bias low warning did not raise interrupt");
    a_bias_lw_unsup: assert property (p_unsup_read(11, `OFF_BIAS_LO_WARN))
        else $error("Unsupported bias low warning read nonzero");
    a_bias_lw_keep: assert property (p_read_keep(11, `OFF_BIAS_LO_WARN))
        else $error("Bias low warning cause lost by read");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    c_read_set_flag: cover property (
        rd_en && mapped ##1 rd_data != 8'h00);
    c_set_during_read: cover property (
        hit[5] && cause_arr[5] != 8'h00 ##1 flag_arr[5] != 8'h00);
    c_int_rise_fall: cover property (
        !flag_int ##1 flag_int [*2] ##1 !flag_int);
    c_back_to_back: cover property (
        rd_en [*3]);
    c_unsup_read: cover property (
        hit[4] && !supported[4]);

endmodule

// ===== tb/lane_flag_host_model.sv
// Host management controller model that reads single flag bytes
`timescale 1ns/1ps
module lane_flag_host_model (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic rd_en,
    output logic [7:0] rd_addr
);
    // ****************************************************************
    // Request lines and read cycle
    // ****************************************************************
    // Idle until the first read
    initial begin
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end

    // One pulse per byte, then a bounded wait for the answer
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
        int waits;
        waits = 0;
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= addr;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        while (rd_valid !== 1'b1 && waits < 4) begin
            @(posedge clk);
            #1;
            waits++;
        end
        // A late answer is poisoned so the bench sees a mismatch
        data = (waits == 0) ? rd_data : 8'hxx;
    endtask
endmodule

// ===== tb/lane_tx_latched_flag_bank_tb.sv
// Self-checking bench for the lane Tx latched flag bank
`timescale 1ns/1ps
`include "lane_tx_flag_consts.svh"
module lane_tx_latched_flag_bank_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    lane_tx_flag_pkg::flag_bank_t causes = '0;
    lane_tx_flag_pkg::flag_bank_t masks = '0;
    logic [3:0] adv_tx = 4'hf;
    logic adv_pwr = 1'b1;
    logic adv_bias = 1'b1;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic flag_int;
    logic [7:0] got;
    logic [7:0] pat;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;

    // ****************************************************************
    // Design, host model and clock
    // ****************************************************************
    lane_tx_latched_flag_bank dut_u (
        .clk(clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr),
        .flag_causes(lane_tx_flag_pkg::flag_bank_s'(causes)),
        .flag_masks(lane_tx_flag_pkg::flag_bank_s'(masks)),
        .adv_tx_flags(adv_tx), .adv_power_mon(adv_pwr), .adv_bias_mon(adv_bias),
        .rd_data(rd_data), .rd_valid(rd_valid), .flag_int(flag_int)
    );

    lane_flag_host_model host_u (
        .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .rd_en(rd_en), .rd_addr(rd_addr)
    );

    // 50 MHz clock
    always #10 clk = ~clk;

    // Cycle ceiling; the full sequence needs well under a thousand
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Read one byte through the host and compare
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host_u.read_byte(a, got);
        check(got, exp);
    endtask

    function automatic logic [7:0] off(input int i);
        return 8'(`OFF_TX_FAILURE + i);
    endfunction

    task automatic give_verdict();
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // All bytes clear out of reset
        for (int i = 0; i < 12; i++) begin
            rd(off(i), 8'h00);
        end
        // Pulse a cause per unmasked byte; bit outlives it, raises the indication
        for (int i = 0; i < 12; i++) begin
            pat = 8'(8'h11 << (i % 4));
            @(posedge clk);
            causes[i] <= pat;
            @(posedge clk);
            causes[i] <= 8'h00;
            repeat (2) @(posedge clk);
            #1;
            check({7'h00, flag_int}, 8'h01);
            rd(off((i + 1) % 12), 8'h00);
            rd(off(i), pat);
            rd(off(i), 8'h00);
        end
        // Mask every bit before unmasking a single lane
        @(posedge clk);
        masks <= '1;
        // Unmasked lane raises the indication; a live cause survives reads
        @(posedge clk);
        masks[5] <= 8'hfd;
        causes[5] <= 8'h03;
        repeat (3) @(posedge clk);
        #1;
        check({7'h00, flag_int}, 8'h01);
        rd(off(5), 8'h03);
        rd(off(5), 8'h03);
        @(posedge clk);
        causes[5] <= 8'h00;
        repeat (2) @(posedge clk);
        rd(off(5), 8'h03);
        rd(off(5), 8'h00);
        @(posedge clk);
        #1;
        check({7'h00, flag_int}, 8'h00);
        // Only a masked lane set: no indication
        @(posedge clk);
        causes[5] <= 8'h01;
        @(posedge clk);
        causes[5] <= 8'h00;
        repeat (3) @(posedge clk);
        #1;
        check({7'h00, flag_int}, 8'h00);
        rd(off(5), 8'h01);
        // Offsets either side of the bank read zero and leave flags alone
        @(posedge clk);
        masks[5] <= 8'hff;
        causes[0] <= 8'h80;
        @(posedge clk);
        causes[0] <= 8'h00;
        rd(8'h86, 8'h00);
        rd(8'h93, 8'h00);
        rd(off(0), 8'h80);
        // Dropping support clears a set byte and keeps it at zero
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            causes[i] <= 8'hff;
            @(posedge clk);
            if (i < 4) adv_tx <= ~(4'h1 << i);
            else if (i < 8) adv_pwr <= 1'b0;
            else adv_bias <= 1'b0;
            repeat (2) @(posedge clk);
            rd(off(i), 8'h00);
            @(posedge clk);
            causes[i] <= 8'h00;
            adv_tx <= 4'hf;
            adv_pwr <= 1'b1;
            adv_bias <= 1'b1;
        end
        // Reset in mid-run wipes a latched bit
        @(posedge clk);
        causes[2] <= 8'h40;
        @(posedge clk);
        causes[2] <= 8'h00;
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(off(2), 8'h00);
        give_verdict();
    end
endmodule
